// ---- rtl/hbsf_consts.vh ----
/*
 hbsf_consts.vh: named constants of the half-bridge serial fault controller.
 Assumes it is included by bare name from the design file, after the timescale.
*/
`ifndef HBSF_CONSTS_VH
`define HBSF_CONSTS_VH

// channel and word sizes
`define HBSF_NUM_CH 8
`define HBSF_WORD_W 16
`define HBSF_GRP0_N 6
`define HBSF_GRP1_N 2

// reset contents of command and status storage
`define HBSF_CMD_RESET 16'h0000
`define HBSF_STAT_RESET 16'h0000

// command word fields
`define HBSF_CMD_SRR 15
`define HBSF_CMD_GRP 14
`define HBSF_CMD_EN_LO 8
`define HBSF_CMD_CFG_LO 2
`define HBSF_CMD_UNDERLOAD_SHUTDOWN_ENABLE 1
`define HBSF_CMD_OVERVOLTAGE_LOCKOUT_ENABLE 0

// status word fields
`define HBSF_ST_OCS 15
`define HBSF_ST_PSF 14
`define HBSF_ST_ULD 13
`define HBSF_ST_HBST_LO 7
`define HBSF_ST_HBCR_LO 1
`define HBSF_ST_TW 0

// frame length check
`define HBSF_MIN_BITS 5'h10
`define HBSF_BYTE_MOD 3'h0

// non-overlap delay between high and low side
`define HBSF_CLK_MHZ 125
`define HBSF_NOVL_NS 500
`define HBSF_NOVL_CYC ((`HBSF_NOVL_NS * `HBSF_CLK_MHZ + 999) / 1000)

`endif

// ---- rtl/hbsf_half_bridge_ctrl.v ----
/*
 hbsf_half_bridge_ctrl.v: serial command port, daisy-chain output path, fault
 latching and shoot-through-safe drive of eight half-bridge channels.
 Assumes one 125 MHz core clock, a synchronous high reset tied to logic power-on,
 and that the serial pins and all fault detectors are asynchronous to the clock.
*/
// What this block does
// - reversed or interleaved words of valid length are still taken as a command
// - serial output ORs thermal-shutdown flag with serial input, muxed with status
// - on chip select fall, the thermal-shutdown pre-bit is driven immediately
// - after the first rising clock edge, the normal status stream is driven
// - reset clears command and status, outputs and serial output high impedance
// - serial frames are accepted only after reset has been released
// - supply undervoltage, or overvoltage if enabled, floats outputs, keeps command and status
// - eight channels form two groups, one command bit picks the group
// - high and low side never on together, non-overlap delay on switching
// - an enabled driver stays on until commanded off or shut down by fault
// - per channel truth table: off Z, low side, high side, fault forces Z
// - protection faults act on outputs, supervisory faults only report
// - thermal and overcurrent latch off; underload latches off only if enabled
// - undervoltage always, overvoltage if enabled, lock out and recover alone
// - commands are taken during lockout and applied once it clears
// - shutdown, overcurrent, underload latch; supply fail and warning do not
// - last 16 bits load only when frame length passes, else frame dropped
// - config status reads zero whenever output status is zero
// - status reset acts at chip select rise, only on the selected group
`timescale 1ns/1ps
`default_nettype none
`include "hbsf_consts.vh"

module hbsf_half_bridge_ctrl (
	input wire core_clk, // 125 MHz core clock
	input wire srst, // synchronous reset, active high
	input wire chip_select_n, // serial chip select, active low, async
	input wire spiClk, // serial clock pin, async
	input wire spiDataIn, // serial data in pin, async
	output reg spiDataOut, // serial data out
	output reg spiDataOutOe, // serial data out enable, high while driven
	input wire supply_undervoltage, // driver supply undervoltage detect, async
	input wire supply_overvoltage, // driver supply overvoltage detect, async
	input wire [`HBSF_NUM_CH-1:0] thermalShutdownDet, // per-channel over-temperature, async
	input wire [`HBSF_NUM_CH-1:0] overcurrentDet, // per-channel overcurrent after delay, async
	input wire [`HBSF_NUM_CH-1:0] underloadDet, // per-channel underload after delay, async
	input wire [`HBSF_NUM_CH-1:0] thermalWarnDet, // per-channel thermal warning, async
	output reg [`HBSF_NUM_CH-1:0] high_side_driver, // high-side gate enables
	output reg [`HBSF_NUM_CH-1:0] low_side_driver // low-side gate enables
);

	localparam integer NOVL_INT = `HBSF_NOVL_CYC;
	localparam [6:0] NOVL_CYC = NOVL_INT[6:0]; // dead time fits seven bits
	localparam [6:0] CNT_ZERO = 7'h00;
	localparam [6:0] CNT_ONE = 7'h01;
	localparam [4:0] BITS_ZERO = 5'h00;
	localparam [4:0] BITS_ONE = 5'h01;
	localparam [2:0] MOD_ZERO = 3'h0;
	localparam [2:0] MOD_ONE = 3'h1;

	// two-flop synchronisers for the serial pins and supply monitors
	reg [2:0] csSync_q;
	reg [2:0] clkSync_q;
	reg [1:0] sdiSync_q;
	reg [1:0] uvSync_q;
	reg [1:0] ovSync_q;

	always @(posedge core_clk)
	begin
		if (srst)
		begin
			csSync_q <= 3'h7;
			clkSync_q <= 3'h0;
			sdiSync_q <= 2'h0;
			uvSync_q <= 2'h0;
			ovSync_q <= 2'h0;
		end
		else
		begin
			csSync_q <= {csSync_q[1:0], chip_select_n};
			clkSync_q <= {clkSync_q[1:0], spiClk};
			sdiSync_q <= {sdiSync_q[0], spiDataIn};
			uvSync_q <= {uvSync_q[0], supply_undervoltage};
			ovSync_q <= {ovSync_q[0], supply_overvoltage};
		end
	end

	// edge detection on the second and third stages only
	wire csFall = csSync_q[2] & ~csSync_q[1];
	wire csRise = ~csSync_q[2] & csSync_q[1];
	wire clkRise = ~clkSync_q[2] & clkSync_q[1];
	wire sdiS = sdiSync_q[1];
	wire uvS = uvSync_q[1];
	wire ovS = ovSync_q[1];

	// frame state and command storage
	reg armed_q; // chip select seen high since reset
	reg inFrame_q;
	reg started_q; // first rising clock edge of frame seen
	reg [`HBSF_WORD_W-1:0] shift_q;
	reg [4:0] bitCnt_q; // saturates at the minimum length
	reg [2:0] modCnt_q; // bits modulo eight
	reg [`HBSF_WORD_W-1:0] cmdWord_q;
	reg [`HBSF_NUM_CH-1:0] enCmd_q;
	reg [`HBSF_NUM_CH-1:0] cfgCmd_q;
	reg [1:0] uldscGrp_q;
	reg overvoltage_lockout_enable_q;
	reg grpSel_q;

	wire frameOk = (bitCnt_q == `HBSF_MIN_BITS) && (modCnt_q == `HBSF_BYTE_MOD);
	wire frameLoad = inFrame_q & csRise & frameOk;
	wire srrNow = frameLoad & shift_q[`HBSF_CMD_SRR];
	wire srrGrp = shift_q[`HBSF_CMD_GRP];

	// status word and fault summaries, built below
	reg [`HBSF_WORD_W-1:0] statWord;
	wire [`HBSF_NUM_CH-1:0] tsdLatch;
	wire [`HBSF_NUM_CH-1:0] ocLatch;
	wire [`HBSF_NUM_CH-1:0] uldLatch;
	wire [`HBSF_NUM_CH-1:0] twS;
	wire [`HBSF_NUM_CH-1:0] stOut;
	wire [`HBSF_NUM_CH-1:0] stCfg;
	wire tsdAny = |tsdLatch;
	wire lockout = uvS | (ovS & overvoltage_lockout_enable_q);

	// serial frame capture and command load
	always @(posedge core_clk)
	begin
		if (srst)
		begin
			armed_q <= 1'b0;
			inFrame_q <= 1'b0;
			started_q <= 1'b0;
			shift_q <= `HBSF_STAT_RESET;
			bitCnt_q <= BITS_ZERO;
			modCnt_q <= MOD_ZERO;
			cmdWord_q <= `HBSF_CMD_RESET;
			enCmd_q <= {`HBSF_NUM_CH{1'b0}};
			cfgCmd_q <= {`HBSF_NUM_CH{1'b0}};
			uldscGrp_q <= 2'h0;
			overvoltage_lockout_enable_q <= 1'b0;
			grpSel_q <= 1'b0;
		end
		else
		begin
			if (csSync_q[1] && !inFrame_q)
				armed_q <= 1'b1;
			if (csFall && armed_q)
			begin
				// status frozen for the whole frame
				inFrame_q <= 1'b1;
				started_q <= 1'b0;
				shift_q <= statWord;
				bitCnt_q <= BITS_ZERO;
				modCnt_q <= MOD_ZERO;
			end
			else if (inFrame_q && csRise)
			begin
				inFrame_q <= 1'b0;
				if (frameOk)
				begin
					// last sixteen bits become the command, word order unchecked
					cmdWord_q <= shift_q;
					grpSel_q <= shift_q[`HBSF_CMD_GRP];
					overvoltage_lockout_enable_q <= shift_q[`HBSF_CMD_OVERVOLTAGE_LOCKOUT_ENABLE];
					if (shift_q[`HBSF_CMD_GRP])
					begin
						enCmd_q[7:6] <= shift_q[`HBSF_CMD_EN_LO+1:`HBSF_CMD_EN_LO];
						cfgCmd_q[7:6] <= shift_q[`HBSF_CMD_CFG_LO+1:`HBSF_CMD_CFG_LO];
						uldscGrp_q[1] <= shift_q[`HBSF_CMD_UNDERLOAD_SHUTDOWN_ENABLE];
					end
					else
					begin
						enCmd_q[5:0] <= shift_q[`HBSF_CMD_EN_LO+5:`HBSF_CMD_EN_LO];
						cfgCmd_q[5:0] <= shift_q[`HBSF_CMD_CFG_LO+5:`HBSF_CMD_CFG_LO];
						uldscGrp_q[0] <= shift_q[`HBSF_CMD_UNDERLOAD_SHUTDOWN_ENABLE];
					end
				end
			end
			else if (inFrame_q && clkRise)
			begin
				// status out MSB first, command in at the bottom
				shift_q <= {shift_q[`HBSF_WORD_W-2:0], sdiS};
				started_q <= 1'b1;
				if (bitCnt_q != `HBSF_MIN_BITS)
					bitCnt_q <= bitCnt_q + BITS_ONE;
				modCnt_q <= modCnt_q + MOD_ONE;
			end
		end
	end

	// serial output: pre-bit path or status stream, floated outside frames
	always @(posedge core_clk)
	begin
		if (srst)
		begin
			spiDataOut <= 1'b0;
			spiDataOutOe <= 1'b0;
		end
		else
		begin
			spiDataOutOe <= inFrame_q | (csFall & armed_q);
			// pre-bit valid with the enable, status bit 15 leaves on the first rise
			if (csFall & armed_q)
				spiDataOut <= tsdAny | sdiS;
			else if (inFrame_q & clkRise)
				spiDataOut <= shift_q[`HBSF_WORD_W-1];
			else if (!started_q)
				spiDataOut <= tsdAny | sdiS;
		end
	end

	// per-channel fault latching and drive sequencing
	genvar i;
	generate
		for (i = 0; i < `HBSF_NUM_CH; i = i + 1)
		begin : gCh
			reg [1:0] tsdSync_q;
			reg [1:0] ocSync_q;
			reg [1:0] uldSync_q;
			reg [1:0] twSync_q;
			reg tsd_q;
			reg oc_q;
			reg uld_q;
			reg uldOff_q;
			reg [6:0] dead_q;
			wire inGrp1 = (i >= `HBSF_GRP0_N);
			wire clr = srrNow & (srrGrp == inGrp1);
			wire shut = tsd_q | oc_q | uldOff_q;
			wire on = enCmd_q[i] & ~shut & ~lockout;
			wire wantHs = on & cfgCmd_q[i];
			wire wantLs = on & ~cfgCmd_q[i];

			always @(posedge core_clk)
			begin
				if (srst)
				begin
					tsdSync_q <= 2'h0;
					ocSync_q <= 2'h0;
					uldSync_q <= 2'h0;
					twSync_q <= 2'h0;
					tsd_q <= 1'b0;
					oc_q <= 1'b0;
					uld_q <= 1'b0;
					uldOff_q <= 1'b0;
				end
				else
				begin
					tsdSync_q <= {tsdSync_q[0], thermalShutdownDet[i]};
					ocSync_q <= {ocSync_q[0], overcurrentDet[i]};
					uldSync_q <= {uldSync_q[0], underloadDet[i]};
					twSync_q <= {twSync_q[0], thermalWarnDet[i]};
					// a new fault beats a clear in the same cycle
					tsd_q <= tsdSync_q[1] | (tsd_q & ~clr);
					oc_q <= ocSync_q[1] | (oc_q & ~clr);
					uld_q <= uldSync_q[1] | (uld_q & ~clr);
					uldOff_q <= (uldSync_q[1] & uldscGrp_q[inGrp1]) | (uldOff_q & ~clr);
				end
			end

			// break before make with a dead time between sides
			always @(posedge core_clk)
			begin
				if (srst)
				begin
					high_side_driver[i] <= 1'b0;
					low_side_driver[i] <= 1'b0;
					dead_q <= CNT_ZERO;
				end
				else if ((high_side_driver[i] & ~wantHs) | (low_side_driver[i] & ~wantLs))
				begin
					high_side_driver[i] <= 1'b0;
					low_side_driver[i] <= 1'b0;
					dead_q <= NOVL_CYC;
				end
				else if (dead_q != CNT_ZERO)
					dead_q <= dead_q - CNT_ONE;
				else
				begin
					high_side_driver[i] <= wantHs;
					low_side_driver[i] <= wantLs & ~wantHs;
				end
			end

			assign tsdLatch[i] = tsd_q;
			assign ocLatch[i] = oc_q;
			assign uldLatch[i] = uld_q;
			assign twS[i] = twSync_q[1];
			assign stOut[i] = on;
			assign stCfg[i] = on & cfgCmd_q[i];
		end
	endgenerate

	// status word for the selected group, supervisory bits report only
	always @*
	begin
		statWord = `HBSF_STAT_RESET;
		statWord[`HBSF_ST_PSF] = uvS | ovS;
		statWord[`HBSF_ST_TW] = |twS;
		if (grpSel_q)
		begin
			statWord[`HBSF_ST_OCS] = |ocLatch[7:6];
			statWord[`HBSF_ST_ULD] = |uldLatch[7:6];
			statWord[`HBSF_ST_HBST_LO+1:`HBSF_ST_HBST_LO] = stOut[7:6];
			statWord[`HBSF_ST_HBCR_LO+1:`HBSF_ST_HBCR_LO] = stCfg[7:6];
		end
		else
		begin
			statWord[`HBSF_ST_OCS] = |ocLatch[5:0];
			statWord[`HBSF_ST_ULD] = |uldLatch[5:0];
			statWord[`HBSF_ST_HBST_LO+5:`HBSF_ST_HBST_LO] = stOut[5:0];
			statWord[`HBSF_ST_HBCR_LO+5:`HBSF_ST_HBCR_LO] = stCfg[5:0];
		end
	end

endmodule
`default_nettype wire

// ---- tb/hbsf_assertions.sv ----
/* hbsf_assertions: port checker of the half-bridge controller.
 Assumes binding to hbsf_half_bridge_ctrl with one core clock. */
`timescale 1ns/1ps
`default_nettype none
module hbsf_assertions (
	input wire core_clk, // core clock
	input wire srst, // sync reset
	input wire chip_select_n, // frame select
	input wire spiClk, // serial clock
	input wire spiDataOut, // serial out
	input wire spiDataOutOe, // serial out enable
	input wire supply_undervoltage, // undervoltage
	input wire [7:0] overcurrentDet, // overcurrent
	input wire [7:0] high_side_driver, // high sides
	input wire [7:0] low_side_driver // low sides
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (srst);
	// set once a serial clock rise is seen in the frame; before it the pre-bit may follow the input
	logic sawClk_q;
	always @(posedge core_clk)
		sawClk_q <= !srst && !chip_select_n && (sawClk_q || spiClk);
	// drive and serial framing relations
	no_shoot_a: assert property (!(high_side_driver & low_side_driver)) else $error("both sides on");
	reset_quiet_a: assert property (disable iff (1'b0) srst |=> !spiDataOutOe && !(high_side_driver | low_side_driver))
		else $error("outputs active in reset");
	oe_start_a: assert property ($fell(chip_select_n) |-> ##[2:6] spiDataOutOe) else $error("no serial out");
	oe_end_a: assert property ($rose(chip_select_n) |-> ##[1:6] !spiDataOutOe) else $error("serial out stuck");
	out_shift_a: assert property (!chip_select_n && spiDataOutOe && $past(spiDataOutOe) && $changed(spiDataOut)
		&& sawClk_q |-> $past(spiClk, 3) || $past(spiClk, 4) || $past(spiClk, 5)) else $error("serial out moved off clock");
	uv_lock_a: assert property (supply_undervoltage [*5] |-> !(high_side_driver | low_side_driver))
		else $error("driven in undervoltage");
	oc_off_a: assert property (!(overcurrentDet & $past(overcurrentDet, 5) & (high_side_driver | low_side_driver)))
		else $error("overcurrent channel driven");
	dead_time_a: assert property ($rose(high_side_driver[0]) |-> !$past(low_side_driver[0], 63))
		else $error("dead time short");
endmodule
bind hbsf_half_bridge_ctrl hbsf_assertions hbsf_assertions_inst (.core_clk, .srst, .chip_select_n, .spiClk,
	.spiDataOut, .spiDataOutOe, .supply_undervoltage, .overcurrentDet, .high_side_driver, .low_side_driver);
`default_nettype wire

// ---- tb/hbsf_spi_host.sv ----
/* hbsf_spi_host: serial host that clocks one frame at a time.
 Assumes an 80 ns serial clock, still between frames. */
`timescale 1ns/1ps
`default_nettype none
module hbsf_spi_host (
	output logic chipSelN, // chip select, active low
	output logic spiClk, // serial clock
	output logic mosi, // data to device
	input wire logic miso // data from device
);
	// idle levels before any frame
	initial
	begin
		chipSelN = 1'b1;
		spiClk = 1'b0;
		mosi = 1'b0;
	end
	// msb first; rx gets the pre-bit then n bits, sampled before each rise
	task automatic frame(input logic [23:0] tx, input int n, output logic [24:0] rx);
		rx = '0;
		// step off the core clock edge so pins never race the synchronisers
		#2 chipSelN = 1'b0;
		#80;
		for (int i = 0; i < n; i++)
		begin
			mosi = tx[n-1-i];
			#40 rx = {rx[23:0], miso};
			spiClk = 1'b1;
			#40 spiClk = 1'b0;
		end
		#40 rx = {rx[23:0], miso};
		mosi = 1'b0;
		#40 chipSelN = 1'b1;
		#80;
	endtask
endmodule
`default_nettype wire

// ---- tb/hbsf_half_bridge_ctrl_bench.sv ----
/* hbsf_half_bridge_ctrl_bench: self-checking bench of the controller.
 Assumes the host model and the bound checker. */
`timescale 1ns/1ps
`default_nettype none
module hbsf_half_bridge_ctrl_bench;
	logic core_clk = 1'b0, srst = 1'b1, uv = 1'b0, ov = 1'b0, csN, sck, si, so, soOe;
	logic [7:0] tsd = '0, oc = '0, underload_flag = '0, tw = '0, hs, ls, enX = '0, cfX = '0;
	logic [24:0] rx;
	logic [15:0] c;
	logic [31:0] lfsr = 32'h92299407;
	int n_mismatch = 0, checks = 0;
	hbsf_spi_host hbsf_spi_host_inst (.chipSelN(csN), .spiClk(sck), .mosi(si), .miso(soOe ? so : ~so));
	hbsf_half_bridge_ctrl hbsf_half_bridge_ctrl_inst (.core_clk, .srst, .chip_select_n(csN), .spiClk(sck),
		.spiDataIn(si), .spiDataOut(so), .spiDataOutOe(soOe), .supply_undervoltage(uv), .supply_overvoltage(ov),
		.thermalShutdownDet(tsd), .overcurrentDet(oc), .underloadDet(underload_flag), .thermalWarnDet(tw),
		.high_side_driver(hs), .low_side_driver(ls));
	// 125 MHz core clock
	initial forever #4 core_clk = ~core_clk;
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	function automatic logic [31:0] nextRand(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	// stored enables and configs after a command word
	task automatic apply(input logic [15:0] w);
		if (w[14])
			{enX[7:6], cfX[7:6]} = {w[9:8], w[3:2]};
		else
			{enX[5:0], cfX[5:0]} = {w[13:8], w[7:2]};
	endtask
	function automatic logic [15:0] stat(input logic g);
		logic [11:0] ec;
		ec = g ? {4'h0, enX[7:6], 4'h0, enX[7:6] & cfX[7:6]} : {enX[5:0], enX[5:0] & cfX[5:0]};
		return {3'h0, ec, 1'b0};
	endfunction
	task automatic xfer(input logic [23:0] tx, input int n);
		hbsf_spi_host_inst.frame(tx, n, rx);
		repeat (120) @(posedge core_clk);
	endtask
	// drivers against stored command, lk marks locked channels
	task automatic drv(input logic [7:0] lk);
		check({hs, ls}, {enX & cfX & ~lk, enX & ~cfX & ~lk});
	endtask
	task automatic test_done;
		if (n_mismatch == 0 && checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// hang guard
	initial
	begin
		#400000;
		n_mismatch++;
		test_done;
	end
	// main sequence
	initial
	begin
		repeat (8) @(posedge core_clk);
		srst <= 1'b0;
		repeat (8) @(posedge core_clk);
		drv(8'h00);
		for (int k = 0; k < 24; k++)
		begin
			c = (k == 0) ? 16'h0309 : (k == 1) ? 16'h0305 : lfsr[15:0] & 16'h7FFE;
			lfsr = nextRand(lfsr);
			xfer(c, 16);
			apply(c);
			drv(8'h00);
			xfer(c, 16);
			check(rx[16:0], {1'b0, stat(c[14])});
		end
		xfer({8'hA5, 16'h3F55}, 24);
		apply(16'h3F55);
		drv(8'h00);
		check(rx[7:0], 8'hA5);
		for (int n = 12; n <= 20; n += 8)
		begin
			xfer(24'h0, n);
			drv(8'h00);
		end
		@(posedge core_clk) uv <= 1'b1;
		repeat (10) @(posedge core_clk);
		xfer(16'h3F01, 16);
		apply(16'h3F01);
		drv(8'hFF);
		check(rx[14], 1'b1);
		@(posedge core_clk) uv <= 1'b0;
		repeat (120) @(posedge core_clk);
		drv(8'h00);
		@(posedge core_clk) ov <= 1'b1;
		repeat (20) @(posedge core_clk);
		drv(8'hFF);
		xfer(16'h3F00, 16);
		drv(8'h00);
		@(posedge core_clk) {ov, oc[0], tsd[2], tw[4]} <= 4'h7;
		repeat (5) @(posedge core_clk);
		{oc[0], tsd[2]} <= 2'b00;
		repeat (20) @(posedge core_clk);
		drv(8'h05);
		xfer(16'h3F00, 16);
		check({rx[16:13], rx[0]}, 5'h19);
		tw[4] <= 1'b0;
		xfer(16'hBF00, 16);
		drv(8'h00);
		xfer(16'h3F00, 16);
		check({rx[16:13], rx[0]}, 5'h00);
		// overvoltage without lockout and underload without shutdown leave outputs alone
		@(posedge core_clk) {ov, underload_flag[3]} <= 2'b11;
		repeat (5) @(posedge core_clk);
		underload_flag[3] <= 1'b0;
		repeat (20) @(posedge core_clk);
		drv(8'h00);
		xfer(16'h3F02, 16);
		check(rx[14:13], 2'b11);
		// underload with shutdown enabled latches its channel off until status reset
		@(posedge core_clk) {ov, underload_flag[4]} <= 2'b01;
		repeat (5) @(posedge core_clk);
		underload_flag[4] <= 1'b0;
		repeat (20) @(posedge core_clk);
		drv(8'h10);
		xfer(16'hBF02, 16);
		drv(8'h00);
		test_done;
	end
endmodule
`default_nettype wire
